/* dhs_axis_model.sv */
// Behavioural axis: encoder index, home and limit switches, end blocks
`timescale 1ns/1ps
`default_nettype none
module dhs_axis_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  move_dir,
    input  wire logic        use_limits,
    output logic             index_pulse,
    output logic             home_switch,
    output logic             limit_neg,
    output logic             limit_pos,
    output logic [15:0]      motor_current,
    output logic             motor_standstill,
    output logic [31:0]      actual_position
);
    logic signed [31:0] pos_q;
    wire push = (move_dir == 2'h1 && pos_q >= 32'sd240) || (move_dir == 2'h2 && pos_q <= -32'sd240);
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) pos_q <= '0;
        else if (!push && move_dir == 2'h1) pos_q <= pos_q + 32'sd1;
        else if (!push && move_dir == 2'h2) pos_q <= pos_q - 32'sd1;
    end
    // Limits sit before the blocks; without them only current and standstill show the block
    assign limit_pos        = use_limits && pos_q >= 32'sd200;
    assign limit_neg        = use_limits && pos_q <= -32'sd200;
    assign home_switch      = pos_q >= 32'sd40 && pos_q <= 32'sd90;
    assign index_pulse      = pos_q[4:0] == 5'h00;
    assign motor_current    = push ? 16'h0800 : 16'h0040;
    assign motor_standstill = move_dir == 2'h0 || push;
    assign actual_position  = pos_q;
endmodule // dhs_axis_model
`default_nettype wire

/* dhs_consts.vh */
// Constants for the homing sequencer: register map, field positions, resets, timing
`ifndef DHS_CONSTS_VH
`define DHS_CONSTS_VH
`define DHS_OFF_CTRL        4'h0
`define DHS_OFF_STATUS      4'h1
`define DHS_OFF_MODE        4'h2
`define DHS_OFF_METHOD      4'h3
`define DHS_OFF_OFFSET      4'h4
`define DHS_OFF_SPD_SWITCH  4'h5
`define DHS_OFF_SPD_ZERO    4'h6
`define DHS_OFF_RAMP        4'h7
`define DHS_OFF_BLK_CURR    4'h8
`define DHS_OFF_BLK_TIME    4'h9
`define DHS_OFF_POS         4'hA
`define DHS_OFF_MAX_TORQUE  4'hB
`define DHS_OFF_TGT_TORQUE  4'hC
`define DHS_OFF_LIMSTOP     4'hD
`define DHS_CTRL_START      4
`define DHS_ST_REACHED      10
`define DHS_ST_LIMIT        11
`define DHS_ST_HOMED        12
`define DHS_ST_ERROR        13
`define DHS_MODE_HOMING     8'h06
`define DHS_RST_LIMSTOP     16'hFFFF
`define DHS_CLK_HZ          20000000
`define DHS_MS_PER_S        1000
`define DHS_CYC_PER_MS      (`DHS_CLK_HZ / `DHS_MS_PER_S)
`define DHS_BLOCK_TIMEOUT   16'hFFFF
`endif

/* dhs_homing.v */
// Homing sequencer with Avalon-MM register slave
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dhs_consts.vh"
// How it works
// - Homing meanings apply only while mode register holds value 6.
// - Control bit 4 rising starts homing; clearing it aborts the run.
// - Status bits 13,12,10 encode running, idle, homed, done, error moving/still.
// - Homed bit 12 sets only after first fully completed run since reset.
// - Bit 12 clears during each later run and stays clear after an error.
// - Home offset is loaded as position when the reference is found.
// - Methods 1-14, 33, 34 finish on the encoder index pulse.
// - Methods 17-30 use same travel but finish on switches, ignoring index.
// - Negative method number replaces limit switch with block detection.
// - Only -1,-2,-7..-14,-17,-18,-23..-30 are valid block methods.
// - Block methods need closed-loop operation, else an error results.
// - Block is detected when motor current exceeds the configured threshold.
// - After block detection methods -1,-2,-17,-18 keep pushing for configured milliseconds; other block methods turn at once.
// - Switch search uses the switch-search speed setting.
// - Index search uses the zero-search speed setting.
// - One ramp value serves for both acceleration and braking.
// - Methods 33 and 34 seek only the next index pulse.
// - Method 35 takes the current position without moving.
// - Method 1 seeks negative limit, method 2 positive limit, then index.
// - Methods 3,4 use home switch left edge; 5,6 its right edge.
// - Methods 7-10 watch positive limit, 11-14 negative limit.
// - Status bit 11 sets while target torque exceeds maximum torque.
module dhs_homing (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        index_pulse,
    input  wire        home_switch,
    input  wire        limit_neg,
    input  wire        limit_pos,
    input  wire [15:0] motor_current,
    input  wire        closed_loop,
    input  wire        motor_standstill,
    input  wire [31:0] actual_position,
    output reg  [1:0]  move_dir,
    output reg  [15:0] move_speed,
    output wire [15:0] move_ramp
);

    localparam ST_IDLE   = 3'd0;
    localparam ST_SEARCH = 3'd1;
    localparam ST_LEAVE  = 3'd2;
    localparam ST_PUSH   = 3'd3;
    localparam ST_INDEX  = 3'd4;
    localparam ST_DONE   = 3'd5;
    localparam ST_ERROR  = 3'd6;

    localparam [1:0] DIR_STOP = 2'd0;
    localparam [1:0] DIR_POS  = 2'd1;
    localparam [1:0] DIR_NEG  = 2'd2;

    localparam [31:0] BLK_CYC = `DHS_CYC_PER_MS;

    reg  [15:0] ctrl_q;
    reg  [7:0]  mode_q;
    reg  [7:0]  method_q;
    reg  [31:0] offset_q;
    reg  [15:0] spd_switch_q;
    reg  [15:0] spd_zero_q;
    reg  [15:0] ramp_q;
    reg  [15:0] blk_curr_q;
    reg  [15:0] blk_time_q;
    reg  [15:0] max_torque_q;
    reg  [15:0] tgt_torque_q;
    reg  [15:0] limstop_q;
    reg  [31:0] pos_q;
    reg  [2:0]  state_q;
    reg         homed_q;
    reg         start_prev_q;
    reg  [31:0] ms_cnt_q;
    reg  [15:0] ms_left_q;
    reg         rd_done_q;
    reg  [2:0]  idx_sync_q;
    reg  [1:0]  home_sync_q;
    reg  [1:0]  lneg_sync_q;
    reg  [1:0]  lpos_sync_q;
    reg         home_prev_q;
    reg  [15:0] status_w;

    wire [7:0] mag     = method_q[7] ? (~method_q + 8'h01) : method_q;
    wire       on_blk  = method_q[7];
    wire       homing  = (mode_q == `DHS_MODE_HOMING);
    wire       start   = ctrl_q[`DHS_CTRL_START];
    wire       idx_evt = idx_sync_q[1] & ~idx_sync_q[2];
    wire       home_s  = home_sync_q[1];
    wire       home_rise = home_s & ~home_prev_q;
    wire       home_fall = ~home_s & home_prev_q;
    wire       blocked = motor_current > blk_curr_q;

    // Fixed single wait state: the first cycle of every access stalls
    assign avs_waitrequest = (avs_read | avs_write) & ~rd_done_q;
    assign move_ramp       = ramp_q;

    // Method class decoding reused for validity and travel
    function valid_method;
        input [7:0] m;
        input       blk;
        begin
            if (blk)
                valid_method = (m == 8'd1) || (m == 8'd2) || (m >= 8'd7 && m <= 8'd14) ||
                               (m == 8'd17) || (m == 8'd18) ||
                               (m >= 8'd23 && m <= 8'd30);
            else
                valid_method = (m >= 8'd1 && m <= 8'd14) || (m >= 8'd17 && m <= 8'd30) ||
                               (m >= 8'd33 && m <= 8'd35);
        end
    endfunction

    // Travel direction of the first search, profiles shared by base and +16 methods
    function [1:0] first_dir;
        input [7:0] m;
        reg   [7:0] b;
        begin
            b = (m >= 8'd17 && m <= 8'd30) ? (m - 8'd16) : m;
            case (b)
                8'd1, 8'd4, 8'd6, 8'd11, 8'd12, 8'd13, 8'd14: first_dir = DIR_NEG;
                8'd2, 8'd3, 8'd5, 8'd7, 8'd8, 8'd9, 8'd10:    first_dir = DIR_POS;
                8'd33:   first_dir = DIR_NEG;
                default: first_dir = DIR_POS;
            endcase
        end
    endfunction

    // Next-index methods skip every switch search
    function index_only;
        input [7:0] m;
        begin
            index_only = (m == 8'd33) || (m == 8'd34);
        end
    endfunction

    // Opposite travel direction, when a limit or block turns the search
    function [1:0] flip_dir;
        input [1:0] d;
        begin
            flip_dir = (d == DIR_NEG) ? DIR_POS : DIR_NEG;
        end
    endfunction

    wire uses_index = (mag >= 8'd1 && mag <= 8'd14) || index_only(mag);
    wire [7:0] base = (mag >= 8'd17) ? (mag - 8'd16) : mag;
    wire limit_type = (base == 8'd1) || (base == 8'd2);
    wire lim_hit    = (move_dir == DIR_NEG) ? lneg_sync_q[1] : lpos_sync_q[1];
    // Right-edge methods wait for the home switch to release
    wire hs_right   = (base == 8'd5) || (base == 8'd6) || (base == 8'd9) || (base == 8'd10) ||
                      (base == 8'd13) || (base == 8'd14);
    // Reference edge of the home switch seen in the travel direction
    wire home_edge  = hs_right ? home_fall : home_rise;
    wire end_hit    = on_blk ? blocked : lim_hit;

    // Input synchronisers
    // Index has a third stage so its rising edge lasts one cycle
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            idx_sync_q  <= 3'b000;
            home_sync_q <= 2'b00;
            lneg_sync_q <= 2'b00;
            lpos_sync_q <= 2'b00;
            home_prev_q <= 1'b0;
        end else begin
            idx_sync_q  <= {idx_sync_q[1:0], index_pulse};
            home_sync_q <= {home_sync_q[0], home_switch};
            lneg_sync_q <= {lneg_sync_q[0], limit_neg};
            lpos_sync_q <= {lpos_sync_q[0], limit_pos};
            home_prev_q <= home_sync_q[1];
        end
    end

    // Reads are captured on the stalled edge and stand at the accepting one;
    // writes land only at the accepting edge, when the master ends the access
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_q       <= 16'h0000;
            mode_q       <= 8'h00;
            method_q     <= 8'h00;
            offset_q     <= 32'h00000000;
            spd_switch_q <= 16'h0000;
            spd_zero_q   <= 16'h0000;
            ramp_q       <= 16'h0000;
            blk_curr_q   <= 16'h0000;
            blk_time_q   <= 16'h0000;
            max_torque_q <= 16'h0000;
            tgt_torque_q <= 16'h0000;
            limstop_q    <= `DHS_RST_LIMSTOP;
            rd_done_q    <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            rd_done_q <= (avs_read | avs_write) & ~rd_done_q;
            if (avs_write & rd_done_q) begin
                case (avs_address)
                    `DHS_OFF_CTRL:       ctrl_q       <= avs_writedata[15:0];
                    `DHS_OFF_MODE:       mode_q       <= avs_writedata[7:0];
                    `DHS_OFF_METHOD:     method_q     <= avs_writedata[7:0];
                    `DHS_OFF_OFFSET:     offset_q     <= avs_writedata;
                    `DHS_OFF_SPD_SWITCH: spd_switch_q <= avs_writedata[15:0];
                    `DHS_OFF_SPD_ZERO:   spd_zero_q   <= avs_writedata[15:0];
                    `DHS_OFF_RAMP:       ramp_q       <= avs_writedata[15:0];
                    `DHS_OFF_BLK_CURR:   blk_curr_q   <= avs_writedata[15:0];
                    `DHS_OFF_BLK_TIME:   blk_time_q   <= avs_writedata[15:0];
                    `DHS_OFF_MAX_TORQUE: max_torque_q <= avs_writedata[15:0];
                    `DHS_OFF_TGT_TORQUE: tgt_torque_q <= avs_writedata[15:0];
                    `DHS_OFF_LIMSTOP:    limstop_q    <= avs_writedata[15:0];
                    default: ;
                endcase
            end
            if (avs_read & ~rd_done_q) begin
                case (avs_address)
                    `DHS_OFF_CTRL:       avs_readdata <= {16'h0000, ctrl_q};
                    `DHS_OFF_STATUS:     avs_readdata <= {16'h0000, status_w};
                    `DHS_OFF_MODE:       avs_readdata <= {24'h000000, mode_q};
                    `DHS_OFF_METHOD:     avs_readdata <= {{24{method_q[7]}}, method_q};
                    `DHS_OFF_OFFSET:     avs_readdata <= offset_q;
                    `DHS_OFF_SPD_SWITCH: avs_readdata <= {16'h0000, spd_switch_q};
                    `DHS_OFF_SPD_ZERO:   avs_readdata <= {16'h0000, spd_zero_q};
                    `DHS_OFF_RAMP:       avs_readdata <= {16'h0000, ramp_q};
                    `DHS_OFF_BLK_CURR:   avs_readdata <= {16'h0000, blk_curr_q};
                    `DHS_OFF_BLK_TIME:   avs_readdata <= {16'h0000, blk_time_q};
                    `DHS_OFF_POS:        avs_readdata <= pos_q;
                    `DHS_OFF_MAX_TORQUE: avs_readdata <= {16'h0000, max_torque_q};
                    `DHS_OFF_TGT_TORQUE: avs_readdata <= {16'h0000, tgt_torque_q};
                    `DHS_OFF_LIMSTOP:    avs_readdata <= {{16{limstop_q[15]}}, limstop_q};
                    default:             avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Status word assembly
    // Outside homing mode bits 13, 12 and 10 belong to other modes and read zero
    always @* begin
        status_w = 16'h0000;
        status_w[`DHS_ST_LIMIT] = tgt_torque_q > max_torque_q;
        if (homing) begin
            case (state_q)
                ST_IDLE: begin
                    status_w[`DHS_ST_HOMED]   = homed_q;
                    status_w[`DHS_ST_REACHED] = ~homed_q;
                end
                ST_DONE: begin
                    status_w[`DHS_ST_HOMED]   = 1'b1;
                    status_w[`DHS_ST_REACHED] = 1'b1;
                end
                ST_ERROR: begin
                    status_w[`DHS_ST_ERROR]   = 1'b1;
                    status_w[`DHS_ST_REACHED] = motor_standstill;
                end
                default: ;
            endcase
        end
    end

    // Sequencer
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q      <= ST_IDLE;
            homed_q      <= 1'b0;
            start_prev_q <= 1'b0;
            pos_q        <= 32'h00000000;
            move_dir     <= DIR_STOP;
            move_speed   <= 16'h0000;
            ms_cnt_q     <= 32'h00000000;
            ms_left_q    <= 16'h0000;
        end else begin
            start_prev_q <= start & homing;
            // Position follows the axis while running; a found reference overrides it
            if (state_q != ST_DONE && state_q != ST_IDLE && state_q != ST_ERROR)
                pos_q <= actual_position;
            if (!homing || !start) begin
                move_dir   <= DIR_STOP;
                move_speed <= 16'h0000;
                if (state_q != ST_ERROR)
                    state_q <= ST_IDLE;
            end else if (on_blk && !closed_loop && state_q != ST_IDLE &&
                         state_q != ST_DONE && state_q != ST_ERROR) begin
                // Losing closed loop mid-run under a block method is an error
                move_dir   <= DIR_STOP;
                move_speed <= 16'h0000;
                state_q    <= ST_ERROR;
            end else begin
                case (state_q)
                    ST_IDLE, ST_DONE, ST_ERROR: begin
                        // A fresh rising of the start bit restarts even after done or error
                        if (!start_prev_q) begin
                            homed_q <= 1'b0;
                            if (!valid_method(mag, on_blk) || (on_blk && !closed_loop)) begin
                                state_q <= ST_ERROR;
                            end else if (mag == 8'd35) begin
                                pos_q   <= offset_q;
                                homed_q <= 1'b1;
                                state_q <= ST_DONE;
                            end else if (index_only(mag)) begin
                                move_dir   <= (mag == 8'd33) ? DIR_NEG : DIR_POS;
                                move_speed <= spd_zero_q;
                                state_q    <= ST_INDEX;
                            end else begin
                                move_dir   <= first_dir(mag);
                                move_speed <= spd_switch_q;
                                state_q    <= ST_SEARCH;
                            end
                        end
                    end
                    ST_SEARCH: begin
                        // On block methods the block stands in for the limit switch
                        if (limit_type) begin
                            if (end_hit) begin
                                if (on_blk) begin
                                    ms_cnt_q  <= 32'h00000000;
                                    ms_left_q <= blk_time_q;
                                    state_q   <= ST_PUSH;
                                end else begin
                                    state_q <= ST_LEAVE;
                                end
                            end
                        end else if (home_edge) begin
                            state_q <= ST_LEAVE;
                        end else if (end_hit) begin
                            move_dir <= flip_dir(move_dir);
                        end
                    end
                    ST_PUSH: begin
                        // Zero blocking time leaves at once; else count whole milliseconds
                        if (ms_left_q == 16'h0000) begin
                            state_q <= ST_LEAVE;
                        end else if (ms_cnt_q == BLK_CYC - 32'd1) begin
                            ms_cnt_q  <= 32'h00000000;
                            ms_left_q <= ms_left_q - 16'h0001;
                        end else begin
                            ms_cnt_q <= ms_cnt_q + 32'd1;
                        end
                    end
                    ST_LEAVE: begin
                        if (uses_index) begin
                            move_speed <= spd_zero_q;
                            // Limit methods turn back toward the reference for the index
                            if (limit_type)
                                move_dir <= flip_dir(move_dir);
                            state_q <= ST_INDEX;
                        end else begin
                            pos_q      <= offset_q;
                            homed_q    <= 1'b1;
                            move_dir   <= DIR_STOP;
                            move_speed <= 16'h0000;
                            state_q    <= ST_DONE;
                        end
                    end
                    ST_INDEX: begin
                        if (idx_evt) begin
                            pos_q      <= offset_q;
                            homed_q    <= 1'b1;
                            move_dir   <= DIR_STOP;
                            move_speed <= 16'h0000;
                            state_q    <= ST_DONE;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // dhs_homing
`default_nettype wire

/* dhs_homing_properties.sv */
// Concurrent checks on the homing sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "dhs_consts.vh"
module dhs_homing_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  move_dir,
    input wire logic [15:0] move_speed,
    input wire logic [15:0] move_ramp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire         wr_t  = avs_write && !avs_waitrequest;
    wire         rd_st = avs_read && !avs_waitrequest && avs_address == `DHS_OFF_STATUS;
    logic [15:0] sw_q, zr_q, tgt_q, max_q;
    logic [7:0]  meth_q;
    // Shadow settings seen on the bus, so checks need no view inside
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {sw_q, zr_q, tgt_q, max_q, meth_q} <= '0;
        end else if (wr_t) begin
            case (avs_address)
                `DHS_OFF_SPD_SWITCH: sw_q <= avs_writedata[15:0];
                `DHS_OFF_SPD_ZERO:   zr_q <= avs_writedata[15:0];
                `DHS_OFF_TGT_TORQUE: tgt_q <= avs_writedata[15:0];
                `DHS_OFF_MAX_TORQUE: max_q <= avs_writedata[15:0];
                `DHS_OFF_METHOD:     meth_q <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("waitrequest low in first request cycle");
    wait_second_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held beyond one wait state");
    dir_legal_a: assert property (move_dir != 2'h3)
        else $error("illegal move direction code");
    ramp_follow_a: assert property (
        wr_t && avs_address == `DHS_OFF_RAMP |=> move_ramp == $past(avs_writedata[15:0]))
        else $error("ramp output does not follow ramp register");
    speed_pick_a: assert property (
        move_dir != 2'h0 |-> move_speed == sw_q || move_speed == zr_q)
        else $error("moving with a speed other than the search speeds");
    still_pos_a: assert property (meth_q == 8'h23 |-> move_dir == 2'h0)
        else $error("motion during current-position homing");
    index_dir_a: assert property (
        (meth_q == 8'h21 || meth_q == 8'h22) && move_dir != 2'h0
        |-> move_dir == (meth_q == 8'h21 ? 2'h2 : 2'h1))
        else $error("wrong direction for next-index homing");
    status_code_a: assert property (rd_st |-> !(avs_readdata[13] && avs_readdata[12]))
        else $error("undefined homing status code read");
    torque_flag_a: assert property (rd_st |-> avs_readdata[11] == (tgt_q > max_q))
        else $error("limit flag disagrees with torque settings");
    abort_stop_a: assert property (
        wr_t && avs_address == `DHS_OFF_CTRL && !avs_writedata[4] |-> ##[1:4] move_dir == 2'h0)
        else $error("motion continues after start bit cleared");
endmodule // dhs_homing_props
bind dhs_homing dhs_homing_props u_props (.sys_clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .move_dir, .move_speed,
    .move_ramp);
`default_nettype wire

/* tb.sv */
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dhs_consts.vh"
module tb;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        closed_loop = 1'b1;
    logic        use_limits = 1'b1;
    wire  [31:0] avs_readdata, actual_position;
    wire         avs_waitrequest, index_pulse, home_switch, limit_neg, limit_pos;
    wire         motor_standstill;
    wire  [15:0] motor_current, move_speed, move_ramp;
    wire  [1:0]  move_dir;
    logic [31:0] rnd = 32'hADF546AD;
    logic [31:0] s, d, off, t;
    logic [7:0]  meth [17] = '{8'h23, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0B, 8'h0E, 8'h11,
                               8'h12, 8'h13, 8'h15, 8'h17, 8'h1B, 8'h1E, 8'h21, 8'h22};
    int          fail_count = 0;
    int          n_checks = 0;
    always #25 sys_clk = ~sys_clk;
    dhs_homing dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .index_pulse, .home_switch, .limit_neg, .limit_pos,
        .motor_current, .closed_loop, .motor_standstill, .actual_position, .move_dir,
        .move_speed, .move_ramp);
    dhs_axis_model axis (.sys_clk, .reset, .move_dir, .use_limits, .index_pulse, .home_switch,
        .limit_neg, .limit_pos, .motor_current, .motor_standstill, .actual_position);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [2:0] code(input logic [31:0] v);
        return {v[13], v[12], v[10]};
    endfunction
    task automatic final_report;
        if (fail_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Sampled at each rising edge, before the design's updates of that edge land
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] wd);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic home(input logic [7:0] m, input logic [2:0] exp, input int lim);
        int n = 0;
        off = rnd;
        rnd = lfsr(rnd);
        wr(`DHS_OFF_OFFSET, off);
        wr(`DHS_OFF_METHOD, {{24{m[7]}}, m});
        wr(`DHS_OFF_CTRL, 32'h0);
        wr(`DHS_OFF_CTRL, 32'h10);
        rd(`DHS_OFF_STATUS, s);
        if (m != 8'h23 && exp == 3'b011) chk(code(s), 3'b000);
        while (code(s) == 3'b000 && n++ < lim) rd(`DHS_OFF_STATUS, s);
        chk(code(s), exp);
        if (exp == 3'b011) begin
            rd(`DHS_OFF_POS, d);
            chk(d, off);
        end
        wr(`DHS_OFF_CTRL, 32'h0);
    endtask
    initial begin
        repeat (90000) @(posedge sys_clk);
        fail_count++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        rd(`DHS_OFF_LIMSTOP, d);
        chk(d, 32'hFFFFFFFF);
        rd(`DHS_OFF_STATUS, d);
        chk(code(d), 3'b000);
        wr(4'hF, rnd);
        rd(4'hF, d);
        chk(d, 32'h0);
        wr(`DHS_OFF_MODE, 32'h6);
        rd(`DHS_OFF_STATUS, d);
        chk(code(d), 3'b001);
        wr(`DHS_OFF_LIMSTOP, 32'hFFFFFFFF);
        rnd = lfsr(rnd);
        wr(`DHS_OFF_SPD_SWITCH, {16'h0, rnd[15:0] | 16'h0001});
        wr(`DHS_OFF_SPD_ZERO, {16'h0, rnd[31:16] | 16'h0001});
        rd(`DHS_OFF_SPD_SWITCH, d);
        chk(d, {16'h0, rnd[15:0] | 16'h0001});
        wr(`DHS_OFF_RAMP, {16'h0, rnd[23:8]});
        wr(`DHS_OFF_BLK_CURR, 32'h400);
        wr(`DHS_OFF_BLK_TIME, 32'h1);
        foreach (meth[i]) home(meth[i], 3'b011, 2000);
        wr(`DHS_OFF_METHOD, 32'h2);
        wr(`DHS_OFF_CTRL, 32'h10);
        wr(`DHS_OFF_CTRL, 32'h0);
        repeat (4) @(posedge sys_clk);
        rd(`DHS_OFF_STATUS, d);
        chk(code(d), 3'b001);
        home(8'h0F, 3'b101, 50);
        home(8'hFD, 3'b101, 50);
        rd(`DHS_OFF_STATUS, d);
        chk(d[12], 1'b0);
        @(posedge sys_clk);
        closed_loop <= 1'b0;
        use_limits <= 1'b0;
        home(8'hFF, 3'b101, 50);
        closed_loop <= 1'b1;
        home(8'hEF, 3'b011, 30000);
        home(8'hF5, 3'b011, 2000);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            t = {17'h0, rnd[14:0]};
            d = (i == 0) ? t : {17'h0, rnd[30:16]};
            wr(`DHS_OFF_TGT_TORQUE, t);
            wr(`DHS_OFF_MAX_TORQUE, d);
            rd(`DHS_OFF_STATUS, s);
            chk(s[11], t > d);
        end
        final_report;
    end
endmodule // tb
`default_nettype wire
